// ==== src/rsa_cfg.svh ====
// Constants for the regulator start-up and address select block
`ifndef RSA_CFG_SVH
`define RSA_CFG_SVH
`define RSA_I2C_BASE_RST 7'h10
`define RSA_PMB_BASE_RST 7'h40
`define RSA_VIN_ON_RST 8'h0A
`define RSA_VIN_OFF_RST 8'h09
`define RSA_SEL_I2C 3'h0
`define RSA_SEL_PMB 3'h1
`define RSA_SEL_VON 3'h2
`define RSA_SEL_VOFF 3'h3
`define RSA_SEL_DLY 3'h4
`define RSA_SEL_RISE 3'h5
`define RSA_SEL_OP 3'h6
`define RSA_CLK_NS 10
`define RSA_MS_NS 1000000
`define RSA_REF_FULL 10'h03E8
`define RSA_DEF_RISE_MS 7'h02
`define RSA_LS_HOLD 4'hF
`define RSA_LS_STEPS 4'h8
`define RSA_FLOAT_CODE 10'h03D7
`define RSA_ADDR_BOUNDS {10'h0383, 10'h0331, 10'h02E8, 10'h029D, 10'h0247, 10'h0208, 10'h01C2, 10'h0186, \
  10'h014E, 10'h011A, 10'h00EA, 10'h00BA, 10'h008F, 10'h0067, 10'h003E}
`endif

// ==== src/rsa_pkg.sv ====
// Types shared by the regulator start-up and address select block
package rsa_pkg;
  typedef struct packed {
    logic [6:0] i2c_base;
    logic [6:0] pmb_base;
    logic [7:0] vin_on;
    logic [7:0] vin_off;
    logic [6:0] ton_delay;
    logic [6:0] ton_rise;
    logic default_cfg;
  } rsa_nv_s;
  typedef enum logic [1:0] {
    INIT_LOAD = 2'b00,
    INIT_CONV = 2'b01,
    INIT_WAIT = 2'b10,
    INIT_RUN = 2'b11
  } rsa_init_e;
  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_DELAY = 2'b01,
    SS_RAMP = 2'b10,
    SS_DONE = 2'b11
  } rsa_ss_e;
endpackage : rsa_pkg

// ==== src/rsa_startup.sv ====
// Start-up, address select and soft-start control of the buck regulator
`timescale 1ns/1ps
`include "rsa_cfg.svh"
// Notes on behaviour
// RULE_01 - Two separate 7-bit base addresses, one for I2C and one for PMBus.
// RULE_02 - A zero base address turns off acknowledging on that bus.
// RULE_03 - Bases reset to 0x10 and 0x40; strap offset adds to each.
// RULE_04 - Strap is converted exactly once during initialization, never again.
// RULE_05 - Strap reading decodes to sixteen offsets, +0 to +15, rising with resistance.
// RULE_06 - After the store load, digital mode answers at base plus offset.
// RULE_07 - Floating strap selects analog mode: bus ignored, three pins go analog.
// RULE_08 - In analog mode working configuration cannot be written.
// RULE_09 - Analog or default config: conversion needs enable pin and input level.
// RULE_10 - Input lockout defaults to 1 V, reprogrammable by turn-on/turn-off levels.
// RULE_11 - Converted input voltage is only reported; comparators make all decisions.
// RULE_12 - Low-side switch stays off until the first high-side pulse.
// RULE_13 - Low-side duty starts at one eighth, rising an eighth per 16 cycles.
// RULE_14 - Reference ramp starts only once conversion is enabled.
// RULE_15 - Analog or default config: reference rises linearly to 0.5 V in 2 ms.
// RULE_16 - Digital mode: ramp start delayed 0 to 127 ms in 1 ms steps.
// RULE_17 - Digital mode: ramp time programmable 1 to 127 ms in 1 ms steps.
// RULE_18 - Overcurrent and overvoltage protection stay armed through start-up.
// RULE_19 - Default config also waits for the address to be read.
// RULE_20 - Offset boundaries sit midway between neighbouring nominal strap readings.
module rsa_startup #(
  parameter int CYC_PER_MS = `RSA_MS_NS / `RSA_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire rsa_pkg::rsa_nv_s nv_cfg,
  input wire logic nv_load_done,
  input wire logic adc_valid,
  input wire logic [9:0] adc_code,
  input wire logic [9:0] vin_adc_code,
  input wire logic host_wr_en,
  input wire logic [2:0] host_wr_sel,
  input wire logic [7:0] host_wr_data,
  input wire logic enable_pin,
  input wire logic vin_ok_cmp,
  input wire logic ocp_trip,
  input wire logic ovp_trip,
  input wire logic sw_cycle_tick,
  input wire logic hs_pulse,
  output logic adc_start,
  output logic [6:0] i2c_addr,
  output logic [6:0] pmb_addr,
  output logic i2c_ack_en,
  output logic pmb_ack_en,
  output logic analog_mode,
  output logic [7:0] vin_on_thr,
  output logic [7:0] vin_off_thr,
  output logic [9:0] vin_report,
  output logic conv_en,
  output logic [9:0] ref_code,
  output logic [3:0] ls_duty,
  output logic prot_armed,
  output logic fault
);
  localparam int STEP_CYC = CYC_PER_MS / int'(`RSA_REF_FULL);

  // Refused at elaboration: the reference needs at least one cycle per step
  if (STEP_CYC < 1) begin : g_bad_step
    $error("CYC_PER_MS too small for the reference resolution");
  end

  // ****************************************
  // Offset decode
  // ****************************************
  // RULE_05 strap to offset
  function automatic logic [3:0] offset_of(input logic [9:0] code);
    logic [149:0] bounds;
    logic [3:0] n;
    bounds = `RSA_ADDR_BOUNDS;
    n = 4'h0;
    for (int i = 0; i < 15; i++) begin
      // RULE_20 midway boundaries
      if (code >= bounds[i*10 +: 10]) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction : offset_of

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] en_sync_r, vin_sync_r, ocp_sync_r, ovp_sync_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_sync_r <= 2'b00;
      vin_sync_r <= 2'b00;
      ocp_sync_r <= 2'b00;
      ovp_sync_r <= 2'b00;
    end else begin
      en_sync_r <= {en_sync_r[0], enable_pin};
      vin_sync_r <= {vin_sync_r[0], vin_ok_cmp};
      ocp_sync_r <= {ocp_sync_r[0], ocp_trip};
      ovp_sync_r <= {ovp_sync_r[0], ovp_trip};
    end
  end
  wire en_s = en_sync_r[1];
  wire vin_s = vin_sync_r[1];
  wire trip_s = ocp_sync_r[1] | ovp_sync_r[1];

  // ****************************************
  // Initialization sequence
  // ****************************************
  rsa_pkg::rsa_init_e init_r, init_nxt;
  logic [3:0] offset_r;
  logic addr_done_r;
  logic [6:0] i2c_base_r, pmb_base_r, dly_ms_r, rise_ms_r;
  logic default_cfg_r, op_on_r;
  wire strap_float = adc_code >= `RSA_FLOAT_CODE;
  wire is_conv = init_r == rsa_pkg::INIT_CONV;
  wire conv_done = init_r == rsa_pkg::INIT_WAIT && adc_valid;

  always_comb begin
    case (init_r)
      rsa_pkg::INIT_LOAD: init_nxt = nv_load_done ? rsa_pkg::INIT_CONV : rsa_pkg::INIT_LOAD;
      rsa_pkg::INIT_CONV: init_nxt = rsa_pkg::INIT_WAIT;
      rsa_pkg::INIT_WAIT: init_nxt = adc_valid ? rsa_pkg::INIT_RUN : rsa_pkg::INIT_WAIT;
      // RULE_04 no further strap reads
      rsa_pkg::INIT_RUN: init_nxt = rsa_pkg::INIT_RUN;
      default: init_nxt = rsa_pkg::INIT_LOAD;
    endcase
  end

  // RULE_08 writes locked in analog mode
  wire wr_ok = host_wr_en && init_r == rsa_pkg::INIT_RUN && !analog_mode;
  wire wr_i2c = wr_ok && host_wr_sel == `RSA_SEL_I2C;
  wire wr_pmb = wr_ok && host_wr_sel == `RSA_SEL_PMB;
  wire [6:0] i2c_base_nxt = wr_i2c ? host_wr_data[6:0] : i2c_base_r;
  wire [6:0] pmb_base_nxt = wr_pmb ? host_wr_data[6:0] : pmb_base_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      init_r <= rsa_pkg::INIT_LOAD;
      adc_start <= 1'b0;
      offset_r <= 4'h0;
      addr_done_r <= 1'b0;
      analog_mode <= 1'b0;
    end else begin
      init_r <= init_nxt;
      adc_start <= is_conv;
      if (conv_done) begin
        // RULE_04 single capture
        offset_r <= offset_of(adc_code);
        addr_done_r <= 1'b1;
        // RULE_07 floating strap
        analog_mode <= strap_float;
      end
    end
  end

  // ****************************************
  // Working configuration
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // RULE_01 two bases
      // RULE_03 base defaults
      i2c_base_r <= `RSA_I2C_BASE_RST;
      pmb_base_r <= `RSA_PMB_BASE_RST;
      // RULE_10 1 V lockout default
      vin_on_thr <= `RSA_VIN_ON_RST;
      vin_off_thr <= `RSA_VIN_OFF_RST;
      dly_ms_r <= 7'h00;
      rise_ms_r <= `RSA_DEF_RISE_MS;
      default_cfg_r <= 1'b1;
      op_on_r <= 1'b0;
    end else if (init_r == rsa_pkg::INIT_LOAD && nv_load_done) begin
      i2c_base_r <= nv_cfg.i2c_base;
      pmb_base_r <= nv_cfg.pmb_base;
      vin_on_thr <= nv_cfg.vin_on;
      vin_off_thr <= nv_cfg.vin_off;
      dly_ms_r <= nv_cfg.ton_delay;
      // A zero rise time in the store would stall the ramp, so keep the default
      rise_ms_r <= (nv_cfg.ton_rise == 7'h00) ? `RSA_DEF_RISE_MS : nv_cfg.ton_rise;
      default_cfg_r <= nv_cfg.default_cfg;
    end else if (wr_ok) begin
      i2c_base_r <= i2c_base_nxt;
      pmb_base_r <= pmb_base_nxt;
      // RULE_10 reprogrammable levels
      if (host_wr_sel == `RSA_SEL_VON) vin_on_thr <= host_wr_data;
      if (host_wr_sel == `RSA_SEL_VOFF) vin_off_thr <= host_wr_data;
      if (host_wr_sel == `RSA_SEL_DLY) dly_ms_r <= host_wr_data[6:0];
      // RULE_17 rise is at least 1 ms
      if (host_wr_sel == `RSA_SEL_RISE && host_wr_data[6:0] != 7'h00) rise_ms_r <= host_wr_data[6:0];
      if (host_wr_sel == `RSA_SEL_OP) op_on_r <= host_wr_data[0];
    end
  end

  // ****************************************
  // Bus address and acknowledge enables
  // ****************************************
  // RULE_06 respond at base plus offset
  wire [6:0] i2c_addr_nxt = 7'(i2c_base_nxt + {3'h0, offset_r});
  wire [6:0] pmb_addr_nxt = 7'(pmb_base_nxt + {3'h0, offset_r});
  wire live = addr_done_r && !analog_mode;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      i2c_addr <= 7'h00;
      pmb_addr <= 7'h00;
      i2c_ack_en <= 1'b0;
      pmb_ack_en <= 1'b0;
      vin_report <= 10'h000;
    end else begin
      i2c_addr <= i2c_addr_nxt;
      pmb_addr <= pmb_addr_nxt;
      // RULE_02 zero base disables
      i2c_ack_en <= live && i2c_base_nxt != 7'h00;
      pmb_ack_en <= live && pmb_base_nxt != 7'h00;
      // RULE_11 report only
      vin_report <= vin_adc_code;
    end
  end

  // ****************************************
  // Conversion enable and protection
  // ****************************************
  wire plain_cfg = analog_mode || default_cfg_r;
  // RULE_09 pin and input gating
  // RULE_19 waits for address read
  wire conv_req = addr_done_r && vin_s && (plain_cfg ? en_s : (en_s || op_on_r));
  // RULE_14 enable prerequisites
  wire conv_nxt = conv_req && !fault && !trip_s;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_en <= 1'b0;
      fault <= 1'b0;
      prot_armed <= 1'b0;
    end else begin
      conv_en <= conv_nxt;
      // RULE_18 protection armed always
      prot_armed <= 1'b1;
      if (trip_s) begin
        fault <= 1'b1;
      end else if (!conv_req) begin
        fault <= 1'b0;
      end
    end
  end

  // ****************************************
  // Soft-start reference ramp
  // ****************************************
  rsa_pkg::rsa_ss_e ss_r, ss_nxt;
  logic [31:0] cyc_r;
  logic [6:0] ms_r;
  // RULE_15 fixed 2 ms without delay
  wire [6:0] dly_eff = plain_cfg ? 7'h00 : dly_ms_r;
  wire [6:0] rise_eff = plain_cfg ? `RSA_DEF_RISE_MS : rise_ms_r;
  wire [31:0] step_len = 32'(rise_eff) * 32'(STEP_CYC);
  wire ms_tick = cyc_r == 32'(CYC_PER_MS - 1);
  wire step_tick = cyc_r == step_len - 32'h0000_0001;
  // RULE_16 start delay
  wire dly_over = ms_r == dly_eff;

  always_comb begin
    case (ss_r)
      rsa_pkg::SS_IDLE: ss_nxt = conv_en ? rsa_pkg::SS_DELAY : rsa_pkg::SS_IDLE;
      rsa_pkg::SS_DELAY: ss_nxt = dly_over ? rsa_pkg::SS_RAMP : rsa_pkg::SS_DELAY;
      rsa_pkg::SS_RAMP: ss_nxt = (step_tick && ref_code == `RSA_REF_FULL - 10'h001) ?
                                 rsa_pkg::SS_DONE : rsa_pkg::SS_RAMP;
      rsa_pkg::SS_DONE: ss_nxt = rsa_pkg::SS_DONE;
      default: ss_nxt = rsa_pkg::SS_IDLE;
    endcase
    if (!conv_en) ss_nxt = rsa_pkg::SS_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !conv_en) begin
      ss_r <= rsa_pkg::SS_IDLE;
      cyc_r <= 32'h0000_0000;
      ms_r <= 7'h00;
      ref_code <= 10'h000;
    end else begin
      ss_r <= ss_nxt;
      if (ss_r == rsa_pkg::SS_DELAY && !dly_over) begin
        cyc_r <= ms_tick ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
        if (ms_tick) ms_r <= ms_r + 7'h01;
      end else if (ss_r == rsa_pkg::SS_RAMP) begin
        // RULE_17 linear ramp over rise time
        cyc_r <= step_tick ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
        if (step_tick) ref_code <= ref_code + 10'h001;
      end
    end
  end

  // ****************************************
  // Pre-bias low-side stepping
  // ****************************************
  logic [3:0] ls_cnt_r;
  wire ls_step = sw_cycle_tick && ls_duty != 4'h0 && ls_duty != `RSA_LS_STEPS && ls_cnt_r == `RSA_LS_HOLD;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !conv_en) begin
      ls_duty <= 4'h0;
      ls_cnt_r <= 4'h0;
    end else if (ls_duty == 4'h0) begin
      // RULE_12 off until high-side pulse
      // RULE_13 first step one eighth
      if (hs_pulse) ls_duty <= 4'h1;
    end else if (sw_cycle_tick && ls_duty != `RSA_LS_STEPS) begin
      // RULE_13 16 cycles per step
      ls_cnt_r <= ls_cnt_r + 4'h1;
      if (ls_step) ls_duty <= ls_duty + 4'h1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_lowside_held: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
    $rose(ls_duty != 4'h0) |-> $past(hs_pulse)) else $error("low side on before high side pulse");
  chk_step_len: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
    (ls_step && conv_en) |=> ls_duty == $past(ls_duty) + 4'h1) else $error("duty step wrong");
  chk_ramp_gated: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
    ref_code != 10'h000 |-> $past(conv_en)) else $error("ramp without enable");
  chk_zero_base: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    (i2c_ack_en |-> i2c_base_r != 7'h00) and (pmb_ack_en |-> pmb_base_r != 7'h00) and
    (analog_mode |-> !i2c_ack_en && !pmb_ack_en)) else $error("ack while disabled");
  chk_analog_lock: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
    (analog_mode && $past(analog_mode)) |-> $stable(vin_on_thr) && $stable(i2c_base_r))
    else $error("config changed in analog mode");
  chk_single_read: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    addr_done_r && $past(addr_done_r) |-> $stable(offset_r) && !adc_start) else $error("strap reread");
  chk_conv_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
    conv_en && plain_cfg |-> $past(en_s) && $past(vin_s) && $past(addr_done_r)) else $error("bad enable");
  chk_addr_sum: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    $past(rst_n) && $stable(i2c_base_r) && $stable(offset_r) |->
    i2c_addr == 7'(i2c_base_r + {3'h0, offset_r}))
    else $error("address not base plus offset");
  chk_trip_stop: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_18
    trip_s |=> !conv_en ##1 !conv_en) else $error("conversion kept on after trip");
endmodule : rsa_startup

// ==== bench/rsa_host_model.sv ====
// Behavioural bus host that issues configuration writes to the block
`timescale 1ns/1ps
module rsa_host_model (
  input wire logic core_clk,
  output logic host_wr_en,
  output logic [2:0] host_wr_sel,
  output logic [7:0] host_wr_data
);
  initial begin
    host_wr_en = 1'b0;
    host_wr_sel = 3'h0;
    host_wr_data = 8'h00;
  end
  // one-cycle command write
  // Idle data shows the inverse of the last value so stale data never looks valid
  task automatic write(input logic [2:0] sel, input logic [7:0] data);
    @(negedge core_clk);
    host_wr_en = 1'b1;
    host_wr_sel = sel;
    host_wr_data = data;
    @(negedge core_clk);
    host_wr_en = 1'b0;
    host_wr_data = ~data;
    repeat (3) @(negedge core_clk);
  endtask : write
endmodule : rsa_host_model

// ==== bench/regulator_startup_and_address_select_test.sv ====
// Self-checking testbench for the start-up and address select block
`timescale 1ns/1ps
`include "rsa_cfg.svh"
module regulator_startup_and_address_select_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  rsa_pkg::rsa_nv_s nv_cfg;
  logic nv_load_done = 1'b0;
  logic adc_valid = 1'b0;
  logic [9:0] adc_code = 10'h0000;
  logic [9:0] vin_adc_code = 10'h0155;
  logic host_wr_en;
  logic [2:0] host_wr_sel;
  logic [7:0] host_wr_data;
  logic enable_pin = 1'b0;
  logic vin_ok_cmp = 1'b0;
  logic ocp_trip = 1'b0;
  logic ovp_trip = 1'b0;
  logic sw_cycle_tick = 1'b0;
  logic hs_pulse = 1'b0;
  logic tick_on = 1'b0;
  logic adc_start, i2c_ack_en, pmb_ack_en, analog_mode, conv_en, prot_armed, fault;
  logic [6:0] i2c_addr, pmb_addr;
  logic [7:0] vin_on_thr, vin_off_thr;
  logic [9:0] vin_report, ref_code;
  logic [3:0] ls_duty;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i;
  initial nv_cfg = '{i2c_base: 7'h10, pmb_base: 7'h40, vin_on: 8'h0A, vin_off: 8'h09,
                     ton_delay: 7'h00, ton_rise: 7'h02, default_cfg: 1'b1};
  always #5 core_clk = ~core_clk;
  // Switching period of four core cycles
  always @(negedge core_clk) sw_cycle_tick <= tick_on && (cycles % 4 == 0);
  rsa_host_model host (.core_clk(core_clk), .host_wr_en(host_wr_en), .host_wr_sel(host_wr_sel),
    .host_wr_data(host_wr_data));
  rsa_startup #(.CYC_PER_MS(1000)) DUT (.core_clk(core_clk), .rst_n(rst_n), .nv_cfg(nv_cfg),
    .nv_load_done(nv_load_done), .adc_valid(adc_valid), .adc_code(adc_code),
    .vin_adc_code(vin_adc_code), .host_wr_en(host_wr_en), .host_wr_sel(host_wr_sel),
    .host_wr_data(host_wr_data), .enable_pin(enable_pin), .vin_ok_cmp(vin_ok_cmp),
    .ocp_trip(ocp_trip), .ovp_trip(ovp_trip), .sw_cycle_tick(sw_cycle_tick), .hs_pulse(hs_pulse),
    .adc_start(adc_start), .i2c_addr(i2c_addr), .pmb_addr(pmb_addr), .i2c_ack_en(i2c_ack_en),
    .pmb_ack_en(pmb_ack_en), .analog_mode(analog_mode), .vin_on_thr(vin_on_thr),
    .vin_off_thr(vin_off_thr), .vin_report(vin_report), .conv_en(conv_en), .ref_code(ref_code),
    .ls_duty(ls_duty), .prot_armed(prot_armed), .fault(fault));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Hang guard well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 30000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : do_reset
  // Store load, one strap conversion, then three edges for addresses to settle
  task automatic start_up(input logic [9:0] code);
    @(negedge core_clk);
    nv_load_done = 1'b1;
    i = 0;
    while (adc_start !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("adc_start", 10'h0001, {9'h000, adc_start});
    @(negedge core_clk);
    adc_code = code;
    adc_valid = 1'b1;
    @(negedge core_clk);
    adc_valid = 1'b0;
    adc_code = ~code;
    repeat (3) @(negedge core_clk);
  endtask : start_up
  task automatic t_digital();
    do_reset();
    @(negedge core_clk);
    chk("prot_armed", 10'h0001, {9'h000, prot_armed});
    chk("i2c_ack_en", 10'h0000, {9'h000, i2c_ack_en});
    start_up(10'h0103);
    chk("i2c_addr", 10'h0015, {3'h0, i2c_addr});
    chk("pmb_addr", 10'h0045, {3'h0, pmb_addr});
    chk("ack_en", 10'h0003, {8'h00, i2c_ack_en, pmb_ack_en});
    chk("analog_mode", 10'h0000, {9'h000, analog_mode});
    chk("vin_on_thr", 10'h000A, {2'h0, vin_on_thr});
    chk("vin_report", 10'h0155, vin_report);
    @(negedge core_clk);
    adc_valid = 1'b1;
    @(negedge core_clk);
    adc_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("i2c_addr again", 10'h0015, {3'h0, i2c_addr});
  endtask : t_digital
  task automatic t_host_writes();
    host.write(`RSA_SEL_I2C, 8'h00);
    chk("i2c_ack_en zero", 10'h0000, {9'h000, i2c_ack_en});
    chk("pmb_ack_en kept", 10'h0001, {9'h000, pmb_ack_en});
    host.write(`RSA_SEL_PMB, 8'h20);
    chk("pmb_addr new", 10'h0025, {3'h0, pmb_addr});
    host.write(`RSA_SEL_VOFF, 8'h30);
    chk("vin_off_thr", 10'h0030, {2'h0, vin_off_thr});
  endtask : t_host_writes
  task automatic t_softstart();
    enable_pin = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("conv_en no vin", 10'h0000, {9'h000, conv_en});
    chk("ref idle", 10'h0000, ref_code);
    vin_ok_cmp = 1'b1;
    tick_on = 1'b1;
    i = 0;
    while (conv_en !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("conv_en", 10'h0001, {9'h000, conv_en});
    repeat (20) @(negedge core_clk);
    chk("ls before pulse", 10'h0000, {6'h00, ls_duty});
    hs_pulse = 1'b1;
    @(negedge core_clk);
    hs_pulse = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("ls first step", 10'h0001, {6'h00, ls_duty});
    i = 0;
    while (ref_code !== `RSA_REF_FULL && i < 2200) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("ramp length", 10'h0001, {9'h000, i >= 1950 && i <= 2050});
    chk("ls steady", 10'h0008, {6'h00, ls_duty});
    @(negedge core_clk);
    ocp_trip = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("fault", 10'h0003, {8'h00, fault, prot_armed});
    chk("conv_en off", 10'h0000, {9'h000, conv_en});
    ocp_trip = 1'b0;
    tick_on = 1'b0;
    enable_pin = 1'b0;
  endtask : t_softstart
  // Digital mode with a non-default store: start delay, rise time, software enable
  task automatic t_custom();
    nv_cfg.default_cfg = 1'b0;
    nv_cfg.ton_delay = 7'h01;
    vin_ok_cmp = 1'b0;
    do_reset();
    start_up(10'h0000);
    chk("i2c_addr plus 0", 10'h0010, {3'h0, i2c_addr});
    host.write(`RSA_SEL_DLY, 8'h02);
    host.write(`RSA_SEL_RISE, 8'h01);
    host.write(`RSA_SEL_RISE, 8'h00);
    host.write(`RSA_SEL_OP, 8'h01);
    chk("conv_en op no vin", 10'h0000, {9'h000, conv_en});
    vin_ok_cmp = 1'b1;
    i = 0;
    while (conv_en !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("conv_en by op", 10'h0001, {9'h000, conv_en});
    i = 0;
    while (ref_code === 10'h000 && i < 2200) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("start delay", 10'h0001, {9'h000, i >= 2000 && i <= 2010});
    i = 0;
    while (ref_code !== `RSA_REF_FULL && i < 1200) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("rise time", 10'h0001, {9'h000, i >= 990 && i <= 1010});
    @(negedge core_clk);
    vin_ok_cmp = 1'b0;
  endtask : t_custom
  task automatic t_analog();
    do_reset();
    start_up(10'h03E0);
    chk("analog_mode", 10'h0001, {9'h000, analog_mode});
    chk("ack_en analog", 10'h0000, {8'h00, i2c_ack_en, pmb_ack_en});
    host.write(`RSA_SEL_VON, 8'h55);
    chk("vin_on locked", 10'h000A, {2'h0, vin_on_thr});
  endtask : t_analog
  initial begin
    t_digital();
    t_host_writes();
    t_softstart();
    t_custom();
    t_analog();
    final_report();
  end
endmodule : regulator_startup_and_address_select_test
